/* File: common/nv_config_defines.svh */
// constants for the non-volatile configuration, erase and boot-strap block
//
// What this block and the programmer do
// R1 - fast programming mode needs test pin and straps 0,1 high, strap 2 low
// R2 - programmer never holds test pin high while strap 0 or 1 is low
// R3 - scan-select pin high selects boundary scan, otherwise normal debug
// R4 - erase pin debounced on slow clock, accepted after at least 200 ms
// R5 - programmer holds erase asserted longer than 220 ms each time; the model holds it for eraseLen cycles and the bench also gives a short press
// R6 - security set only by command; cleared only by erase then full erase
// R7 - security set refuses debug and fast programming flash access
// R8 - each nv bit set or cleared by command and kept over power loss
// R9 - nv bit 0 enables brownout detector; accepted erase clears it
// R10 - nv bit 1 enables brownout reset; accepted erase clears it
// R11 - eight calibration bits read-only and untouched by erase
// R12 - nv bit 2 at boot: one boots flash, zero maps boot loader at zero
// R13 - brownout raised only after supply low longer than about 1 us
// R14 - power-on reset held until core supply passes threshold
// R15 - erase synchronised to slow clock; early release restarts count
`ifndef NV_CONFIG_DEFINES_SVH
`define NV_CONFIG_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define BO_FILTER_NS 1000
`define BO_FILTER_CYCLES ((`BO_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BO_COUNT_W 5
`define ERASE_DEBOUNCE_MS 200
`define SLOW_CLOCK_MAX_KHZ 42
`define ERASE_DEBOUNCE_TICKS (`ERASE_DEBOUNCE_MS * `SLOW_CLOCK_MAX_KHZ)
`define ERASE_COUNT_W 14

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define REG_CMD_ADDR 8'h00
`define REG_NV_ADDR 8'h04
`define REG_CALIB_ADDR 8'h08
`define REG_STATUS_ADDR 8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_W 3
`define CMD_IDX_LSB 4
`define CMD_IDX_W 2
`define NV_BITS_W 3
`define NV_SEC_POS 4
`define CALIB_W 8
`define ST_FASTPROG_POS 0
`define ST_SCAN_POS 1
`define ST_BOOTROM_POS 2
`define ST_BROWNOUT_POS 3
`define ST_BORESET_POS 4
`define ST_POR_POS 5
`define ST_ERASEPEND_POS 6
`define ST_DEBOUNCED_POS 7

`endif

/* File: common/nv_config_pkg.sv */
// types for the non-volatile configuration, erase and boot-strap block
package nv_config_pkg;

typedef enum logic [2:0] {
    NV_OP_NONE = 3'b000,
    NV_OP_SET_BIT = 3'b001,
    NV_OP_CLR_BIT = 3'b010,
    NV_OP_SET_SEC = 3'b011
} nv_op_t;

typedef enum logic [1:0] {
    DB_IDLE = 2'b00,
    DB_COUNT = 2'b01,
    DB_HELD = 2'b10
} db_state_t;

typedef struct packed {
    db_state_t state;
    logic [13:0] count;
    logic accepted;
} debounce_t;

typedef struct packed {
    logic [1:0] testSync;
    logic [1:0] strap0Sync;
    logic [1:0] strap1Sync;
    logic [1:0] strap2Sync;
    logic [1:0] scanSync;
    logic [1:0] eraseSync;
    logic [1:0] slowSync;
    logic [1:0] coreLowSync;
    logic [1:0] flashLowSync;
    logic [1:0] coreOkSync;
    logic slowPrev;
    logic slowTick;
    logic [2:0] nvBits;
    logic security;
    logic [7:0] calib;
    logic erasePending;
    logic eraseRequest;
    logic fastProgMode;
    logic boundaryScanMode;
    logic bootFromRom;
    logic [4:0] boCount;
    logic brownout;
    logic brownoutReset;
    logic porActive;
    logic debugGrant;
    logic fastProgGrant;
    logic ack;
    logic [31:0] rdata;
} cfg_state_t;

endpackage

/* File: logic/erase_debounce.sv */
// erase pin debouncer counting slow clock ticks
`timescale 1ns/1ns
`include "nv_config_defines.svh"

module erase_debounce #(
    parameter int DEBOUNCE_TICKS = `ERASE_DEBOUNCE_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // from the main block
    input wire logic slowTick,
    input wire logic eraseLevel,
    output logic eraseAccepted
);
    import nv_config_pkg::*;

    debounce_t cur;
    debounce_t next_cur;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.accepted = 1'b0;
        // R15 restart on release
        if (!eraseLevel) begin
            next_cur.state = DB_IDLE;
            next_cur.count = '0;
        end else if (slowTick) begin
            // R15 sample on slow tick
            case (cur.state)
                DB_IDLE: begin
                    next_cur.state = DB_COUNT;
                    next_cur.count = 14'h0001;
                end
                DB_COUNT: begin
                    // R4 at least the debounce time
                    if (cur.count >= DEBOUNCE_TICKS[13:0]) begin
                        next_cur.state = DB_HELD;
                        next_cur.accepted = 1'b1;
                    end else begin
                        next_cur.count = cur.count + 14'h0001;
                    end
                end
                DB_HELD: begin
                    // one erase per press
                    next_cur.state = DB_HELD;
                end
                default: begin
                    next_cur.state = DB_IDLE;
                    next_cur.count = '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cur <= '{state: DB_IDLE, count: 14'h0000, accepted: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign eraseAccepted = cur.accepted;

endmodule // erase_debounce

/* File: logic/nv_config_erase_boot.sv */
// non-volatile configuration bits, erase handling, mode straps and supply monitors
`timescale 1ns/1ns
`include "nv_config_defines.svh"

module nv_config_erase_boot #(
    parameter int ERASE_DEBOUNCE_TICKS = `ERASE_DEBOUNCE_TICKS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // pins and straps
    input wire logic test_mode_pin,
    input wire logic scan_select_pin,
    input wire logic mode_strap_0,
    input wire logic mode_strap_1,
    input wire logic mode_strap_2,
    input wire logic erasePin,
    input wire logic slow_clock,
    // non-volatile array
    input wire logic [2:0] nvPowerUpBits,
    input wire logic nvPowerUpSecurity,
    input wire logic [7:0] factoryCalib,
    output logic [2:0] general_purpose_nv_bits,
    output logic securityBit,
    // flash controller
    input wire logic fullEraseDone,
    output logic fullEraseRequest,
    // access requests
    input wire logic debugAccessReq,
    input wire logic fastProgAccessReq,
    output logic debugAccessGrant,
    output logic fastProgAccessGrant,
    // supply monitors
    input wire logic coreBelowThreshold,
    input wire logic flashBelowThreshold,
    input wire logic coreSupplyOk,
    // modes and resets
    output logic fastProgMode,
    output logic boundaryScanMode,
    output logic bootFromRom,
    output logic [7:0] calibOut,
    output logic brownoutDetected,
    output logic brownoutResetReq,
    output logic powerOnReset
);
    import nv_config_pkg::*;

    cfg_state_t cur;
    cfg_state_t next_cur;
    logic eraseAccepted;
    logic eraseDebounced;

    // decodes a register address into its read value
    function automatic logic [31:0] readValue(input logic [7:0] addr, input cfg_state_t s,
                                              input logic debounced);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `REG_NV_ADDR: begin
                v[`NV_BITS_W-1:0] = s.nvBits;
                v[`NV_SEC_POS] = s.security;
            end
            `REG_CALIB_ADDR: begin
                v[`CALIB_W-1:0] = s.calib;
            end
            `REG_STATUS_ADDR: begin
                v[`ST_FASTPROG_POS] = s.fastProgMode;
                v[`ST_SCAN_POS] = s.boundaryScanMode;
                v[`ST_BOOTROM_POS] = s.bootFromRom;
                v[`ST_BROWNOUT_POS] = s.brownout;
                v[`ST_BORESET_POS] = s.brownoutReset;
                v[`ST_POR_POS] = s.porActive;
                v[`ST_ERASEPEND_POS] = s.erasePending;
                v[`ST_DEBOUNCED_POS] = debounced;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // index of an existing nv bit
    function automatic logic validIndex(input logic [1:0] i);
        return i < 2'(`NV_BITS_W);
    endfunction

    // ----------------------------------------
    // erase debouncer
    // ----------------------------------------
    erase_debounce #(
        .DEBOUNCE_TICKS(ERASE_DEBOUNCE_TICKS)
    ) i_erase_debounce (
        .sys_clk(sys_clk),
        .srst(srst),
        .slowTick(cur.slowTick),
        .eraseLevel(cur.eraseSync[1]),
        .eraseAccepted(eraseAccepted)
    );

    // pending flag doubles as "debounce passed, erase not yet finished"
    assign eraseDebounced = cur.erasePending;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] idx;
        logic [2:0] op;
        logic wrCmd;
        logic below;
        logic busReq;
        idx = 2'b00;
        op = 3'b000;
        wrCmd = 1'b0;
        below = 1'b0;
        busReq = 1'b0;
        next_cur = cur;

        // ----------------------------------------
        // pin synchronisers
        // ----------------------------------------
        // two-stage synchronisers, first stage feeds only the second
        next_cur.testSync = {cur.testSync[0], test_mode_pin};
        next_cur.strap0Sync = {cur.strap0Sync[0], mode_strap_0};
        next_cur.strap1Sync = {cur.strap1Sync[0], mode_strap_1};
        next_cur.strap2Sync = {cur.strap2Sync[0], mode_strap_2};
        next_cur.scanSync = {cur.scanSync[0], scan_select_pin};
        next_cur.eraseSync = {cur.eraseSync[0], erasePin};
        next_cur.slowSync = {cur.slowSync[0], slow_clock};

        // supply comparators are asynchronous too
        next_cur.coreLowSync = {cur.coreLowSync[0], coreBelowThreshold};
        next_cur.flashLowSync = {cur.flashLowSync[0], flashBelowThreshold};
        next_cur.coreOkSync = {cur.coreOkSync[0], coreSupplyOk};

        // ----------------------------------------
        // slow clock tick
        // ----------------------------------------
        // rising edge of the slow clock as a one-cycle tick
        next_cur.slowPrev = cur.slowSync[1];
        next_cur.slowTick = cur.slowSync[1] & ~cur.slowPrev;

        // ----------------------------------------
        // mode straps
        // ----------------------------------------
        // R1 exact strap pattern
        next_cur.fastProgMode = cur.testSync[1] & cur.strap0Sync[1] & cur.strap1Sync[1]
            & ~cur.strap2Sync[1];
        // R3 scan select
        next_cur.boundaryScanMode = cur.scanSync[1];

        // ----------------------------------------
        // access gating
        // ----------------------------------------
        // grant lags the request a cycle; requester waits for it
        // R7 security blocks external paths
        next_cur.debugGrant = debugAccessReq & ~cur.security;
        next_cur.fastProgGrant = fastProgAccessReq & ~cur.security & cur.fastProgMode;

        // ----------------------------------------
        // commands from the bus
        // ----------------------------------------
        busReq = cyc_i & stb_i;
        // command lands at the edge where the master sees ack
        wrCmd = busReq & we_i & cur.ack & sel_i[0] & (adr_i == `REG_CMD_ADDR);
        op = dat_i[`CMD_OP_LSB +: `CMD_OP_W];
        idx = dat_i[`CMD_IDX_LSB +: `CMD_IDX_W];
        if (wrCmd) begin
            case (op)
                NV_OP_SET_BIT: begin
                    // R8 set one bit
                    if (validIndex(idx)) begin
                        next_cur.nvBits[idx] = 1'b1;
                    end
                end
                NV_OP_CLR_BIT: begin
                    // R8 clear one bit
                    if (validIndex(idx)) begin
                        next_cur.nvBits[idx] = 1'b0;
                    end
                end
                NV_OP_SET_SEC: begin
                    // R6 set by command only
                    next_cur.security = 1'b1;
                end
                default: begin
                    next_cur.security = next_cur.security;
                end
            endcase
        end

        // ----------------------------------------
        // erase sequence
        // ----------------------------------------
        next_cur.eraseRequest = 1'b0;
        if (cur.erasePending && fullEraseDone) begin
            // pending ties the clear to an erase begun at the pin
            // R6 cleared after full erase
            next_cur.security = 1'b0;
            next_cur.erasePending = 1'b0;
        end
        if (eraseAccepted) begin
            // a new erase wins over a finishing one
            next_cur.erasePending = 1'b1;
            next_cur.eraseRequest = 1'b1;
            // R9 detector off by default
            next_cur.nvBits[0] = 1'b0;
            // R10 brownout reset off by default
            next_cur.nvBits[1] = 1'b0;
            // R11 calibration left untouched
            next_cur.calib = cur.calib;
        end

        // ----------------------------------------
        // brownout filter
        // ----------------------------------------
        below = cur.coreLowSync[1] | cur.flashLowSync[1];
        // count stops at the limit, a long dip cannot wrap
        // R9 detector enable
        if (!cur.nvBits[0] || !below) begin
            next_cur.boCount = '0;
            next_cur.brownout = 1'b0;
        end else if (cur.boCount < 5'(`BO_FILTER_CYCLES)) begin
            next_cur.boCount = cur.boCount + 5'h01;
        end else begin
            // R13 only dips over 1 us
            next_cur.brownout = 1'b1;
        end
        // R10 reset gated by bit 1
        next_cur.brownoutReset = cur.brownout & cur.nvBits[1];

        // ----------------------------------------
        // power-on reset
        // ----------------------------------------
        // R14 held until core supply good
        next_cur.porActive = ~cur.coreOkSync[1];

        // ----------------------------------------
        // wishbone answer
        // ----------------------------------------
        // one wait state, ack drops the cycle after it rose
        next_cur.ack = busReq & ~cur.ack;
        if (busReq && !cur.ack && !we_i) begin
            next_cur.rdata = readValue(adr_i, cur, eraseDebounced);
        end else begin
            next_cur.rdata = 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cur <= '0;
            // R8 values retained by the array
            cur.nvBits <= nvPowerUpBits;
            cur.security <= nvPowerUpSecurity;
            // R11 factory values
            cur.calib <= factoryCalib;
            // R12 boot source fixed at boot
            cur.bootFromRom <= ~nvPowerUpBits[2];
            cur.porActive <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    assign dat_o = cur.rdata;
    assign ack_o = cur.ack;

    // nv array and flash controller
    assign general_purpose_nv_bits = cur.nvBits;
    assign securityBit = cur.security;
    assign fullEraseRequest = cur.eraseRequest;

    // grants and modes
    assign debugAccessGrant = cur.debugGrant;
    assign fastProgAccessGrant = cur.fastProgGrant;
    assign fastProgMode = cur.fastProgMode;
    assign boundaryScanMode = cur.boundaryScanMode;
    assign bootFromRom = cur.bootFromRom;
    assign calibOut = cur.calib;

    // supply monitors
    assign brownoutDetected = cur.brownout;
    assign brownoutResetReq = cur.brownoutReset;
    assign powerOnReset = cur.porActive;

endmodule // nv_config_erase_boot

/* File: testbench/nv_config_erase_boot_asserts.sv */
// assertion checker bound to the configuration, erase and boot-strap block
`timescale 1ns/1ns
module nv_config_erase_boot_asserts #(
    parameter int ERASE_DEBOUNCE_TICKS = 8400
) (
    // clock, reset and bus
    input logic sys_clk, srst, we_i, cyc_i, stb_i, ack_o,
    input logic [7:0] adr_i,
    input logic [31:0] dat_i,
    // pins
    input logic test_mode_pin, scan_select_pin, mode_strap_0, mode_strap_1, mode_strap_2,
    // nv state and flash
    input logic [2:0] general_purpose_nv_bits,
    input logic [7:0] calibOut,
    input logic securityBit, fullEraseDone, fullEraseRequest,
    // access, modes and brownout
    input logic debugAccessReq, fastProgAccessReq, debugAccessGrant, fastProgAccessGrant,
    input logic fastProgMode, boundaryScanMode, brownoutDetected, brownoutResetReq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    property p_ackAnswer;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ackAnswer: assert property (p_ackAnswer) else $error("request not acked after one wait");
    property p_ackPulse;
        ack_o |=> !ack_o;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
    property p_secSet;
        $rose(securityBit) |-> $past(cyc_i) && $past(stb_i) && $past(we_i) && $past(adr_i) == 8'h00
            && $past(dat_i[2:0]) == 3'h3;
    endproperty
    a_secSet: assert property (p_secSet) else $error("security set without command");
    property p_secClear;
        $fell(securityBit) |-> $past(fullEraseDone);
    endproperty
    a_secClear: assert property (p_secClear) else $error("security cleared without full erase");
    property p_debugGrant;
        !$past(srst) |-> debugAccessGrant == ($past(debugAccessReq) && !$past(securityBit));
    endproperty
    a_debugGrant: assert property (p_debugGrant) else $error("debug grant wrong");
    property p_fastGrant;
        !$past(srst) |-> fastProgAccessGrant ==
            ($past(fastProgAccessReq) && !$past(securityBit) && $past(fastProgMode));
    endproperty
    a_fastGrant: assert property (p_fastGrant) else $error("fast programming grant wrong");
    property p_eraseClr;
        fullEraseRequest |-> general_purpose_nv_bits[1:0] == 2'h0;
    endproperty
    a_eraseClr: assert property (p_eraseClr) else $error("erase left brownout bits set");
    property p_calib;
        !$past(srst) |-> $stable(calibOut);
    endproperty
    a_calib: assert property (p_calib) else $error("calibration changed");
    property p_fastMode;
        !$past(srst) && !$past(srst, 4) |-> fastProgMode == ($past(test_mode_pin, 3) && $past(mode_strap_0, 3)
            && $past(mode_strap_1, 3) && !$past(mode_strap_2, 3));
    endproperty
    a_fastMode: assert property (p_fastMode) else $error("fast mode decode wrong");
    property p_scanMode;
        !$past(srst) && !$past(srst, 4) |-> boundaryScanMode == $past(scan_select_pin, 3);
    endproperty
    a_scanMode: assert property (p_scanMode) else $error("scan select wrong");
    property p_boReset;
        !$past(srst) |-> brownoutResetReq ==
            ($past(brownoutDetected) && $past(general_purpose_nv_bits[1]));
    endproperty
    a_boReset: assert property (p_boReset) else $error("brownout reset gating wrong");
endmodule // nv_config_erase_boot_asserts

bind nv_config_erase_boot nv_config_erase_boot_asserts #(
    .ERASE_DEBOUNCE_TICKS(ERASE_DEBOUNCE_TICKS)
) i_nv_config_erase_boot_asserts (.*);

/* File: testbench/strap_programmer_model.sv */
// board straps, rc slow clock and production programmer driving the mode pins
`timescale 1ns/1ns
module strap_programmer_model #(
    parameter int SLOW_HALF = 8
) (
    // clock
    input logic sys_clk,
    // requests from the bench
    input logic fastReq, strap2Req, scanReq, eraseGo,
    input logic [8:0] eraseLen,
    // pins
    output logic test_mode_pin, scan_select_pin, mode_strap_0, mode_strap_1, mode_strap_2,
    output logic erasePin, slow_clock
);
    int slowCnt = 0;
    int eraseCnt = 0;

    initial begin
        {test_mode_pin, scan_select_pin, mode_strap_0, mode_strap_1, mode_strap_2} = 5'h00;
        {erasePin, slow_clock} = 2'h0;
    end

    always @(posedge sys_clk) begin
        // rc oscillator runs free, shortened period
        slowCnt <= (slowCnt == SLOW_HALF - 1) ? 0 : slowCnt + 1;
        if (slowCnt == SLOW_HALF - 1) begin
            slow_clock <= !slow_clock;
        end
        // straps high before test pin rises, kept until it falls
        mode_strap_0 <= fastReq || test_mode_pin;
        mode_strap_1 <= fastReq || test_mode_pin;
        mode_strap_2 <= strap2Req;
        test_mode_pin <= fastReq && mode_strap_0 && mode_strap_1;
        scan_select_pin <= scanReq;
        // erase held for the whole requested span, pull-down after
        eraseCnt <= eraseGo ? int'(eraseLen) : (eraseCnt > 0 ? eraseCnt - 1 : 0);
        erasePin <= eraseCnt > 0;
    end
endmodule // strap_programmer_model

/* File: testbench/nv_config_erase_boot_tb_top.sv */
// self-checking bench for the configuration, erase and boot-strap block
`timescale 1ns/1ns
module nv_config_erase_boot_tb_top;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] wdat;
        logic [31:0] exp;
    } row_t;
    // bus rows: reads compare, writes only act
    localparam row_t ROWS [14] = '{
        '{1'h0, 8'h04, 32'h0, 32'h4}, '{1'h0, 8'h08, 32'h0, 32'hA5},
        '{1'h1, 8'h00, 32'h01, 32'h0}, '{1'h1, 8'h00, 32'h11, 32'h0},
        '{1'h1, 8'h00, 32'h22, 32'h0}, '{1'h1, 8'h00, 32'h31, 32'h0},
        '{1'h1, 8'h00, 32'h05, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h3},
        '{1'h1, 8'h08, 32'hFF, 32'h0}, '{1'h0, 8'h08, 32'h0, 32'hA5},
        '{1'h0, 8'h0C, 32'h0, 32'h0}, '{1'h0, 8'h40, 32'h0, 32'h0},
        '{1'h1, 8'h40, 32'hFF, 32'h0}, '{1'h0, 8'h04, 32'h0, 32'h3}
    };
    logic sys_clk = 1'h0, srst = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [3:0] sel_i = 4'hF;
    logic debugAccessReq = 1'h0, fastProgAccessReq = 1'h0, fullEraseDone = 1'h0;
    logic coreBelowThreshold = 1'h0, flashBelowThreshold = 1'h0, coreSupplyOk = 1'h1;
    logic fastReq = 1'h0, strap2Req = 1'h0, scanReq = 1'h0, eraseGo = 1'h0;
    logic [8:0] eraseLen = 9'h000;
    logic [2:0] nvPowerUpBits = 3'h4, general_purpose_nv_bits;
    logic nvPowerUpSecurity = 1'h0;
    logic [7:0] factoryCalib = 8'hA5, calibOut;
    logic ack_o, test_mode_pin, scan_select_pin, mode_strap_0, mode_strap_1, mode_strap_2;
    logic erasePin, slow_clock, securityBit, fullEraseRequest, debugAccessGrant, fastProgAccessGrant;
    logic fastProgMode, boundaryScanMode, bootFromRom, brownoutDetected, brownoutResetReq, powerOnReset;
    int errorCnt = 0;
    int checks = 0;
    int n;

    // short debounce keeps the run brief
    nv_config_erase_boot #(.ERASE_DEBOUNCE_TICKS(4)) i_nv_config_erase_boot (.*);
    strap_programmer_model i_strap_programmer_model (.*);

    always #20 sys_clk = !sys_clk;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // classic cycle: hold until ack, then idle one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack_o !== 1'h1);
        r = dat_o;
        chk("bus wait", k, 2);
        {cyc_i, stb_i, we_i} <= 3'h0;
        @(posedge sys_clk);
    endtask

    task automatic erase(input logic [8:0] len);
        eraseLen <= len;
        eraseGo <= 1'h1;
        @(posedge sys_clk);
        eraseGo <= 1'h0;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        tick(5000);
        errorCnt++;
        conclude();
    end

    initial begin
        tick(12);
        srst <= 1'h0;
        tick(1);
        foreach (ROWS[i]) begin
            wb(ROWS[i].we, ROWS[i].adr, ROWS[i].wdat, q);
            if (!ROWS[i].we) chk("row read", q, ROWS[i].exp);
        end
        // dip shorter than the filter
        coreBelowThreshold <= 1'h1;
        tick(20);
        coreBelowThreshold <= 1'h0;
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (brownoutDetected === 1'h1) n++;
        end
        chk("short dip", n, 0);
        flashBelowThreshold <= 1'h1;
        n = 0;
        while (brownoutDetected !== 1'h1 && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        chk("dip filter", n > 25 && n < 60, 1'h1);
        tick(2);
        chk("brownout reset", brownoutResetReq, 1'h1);
        flashBelowThreshold <= 1'h0;
        tick(6);
        chk("brownout release", brownoutDetected, 1'h0);
        wb(1'h1, 8'h00, 32'h03, q);
        {debugAccessReq, fastProgAccessReq, fastReq, strap2Req} <= 4'hF;
        tick(10);
        chk("strap 2 high", fastProgMode, 1'h0);
        {strap2Req, scanReq} <= 2'h1;
        tick(10);
        chk("fast mode", fastProgMode, 1'h1);
        chk("scan mode", boundaryScanMode, 1'h1);
        chk("debug refused", debugAccessGrant, 1'h0);
        chk("fast refused", fastProgAccessGrant, 1'h0);
        erase(9'h028);
        n = 0;
        repeat (120) begin
            @(posedge sys_clk);
            if (fullEraseRequest === 1'h1) n++;
        end
        chk("short erase", n, 0);
        erase(9'h0C8);
        n = 0;
        while (fullEraseRequest !== 1'h1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        chk("debounce span", n >= 64 && n < 300, 1'h1);
        tick(1);
        chk("erase pulse", fullEraseRequest, 1'h0);
        wb(1'h0, 8'h04, 32'h0, q);
        chk("nv after erase", q, 32'h10);
        wb(1'h0, 8'h0C, 32'h0, q);
        chk("status pending", q, 32'hC3);
        wb(1'h0, 8'h08, 32'h0, q);
        chk("calib kept", q, 32'hA5);
        chk("calib out", calibOut, 8'hA5);
        fullEraseDone <= 1'h1;
        tick(1);
        fullEraseDone <= 1'h0;
        tick(3);
        chk("security cleared", securityBit, 1'h0);
        chk("debug granted", debugAccessGrant, 1'h1);
        chk("fast granted", fastProgAccessGrant, 1'h1);
        coreSupplyOk <= 1'h0;
        tick(5);
        chk("power-on reset", powerOnReset, 1'h1);
        coreSupplyOk <= 1'h1;
        tick(5);
        chk("power-on release", powerOnReset, 1'h0);
        {fastReq, scanReq, debugAccessReq, fastProgAccessReq} <= 4'h0;
        nvPowerUpBits <= 3'h3;
        srst <= 1'h1;
        tick(4);
        srst <= 1'h0;
        tick(2);
        chk("reload bits", general_purpose_nv_bits, 3'h3);
        chk("boot from rom", bootFromRom, 1'h1);
        conclude();
    end
endmodule // nv_config_erase_boot_tb_top
